// ---- threshold_relay_output.sv ----
// threshold relay output: compare, hysteresis, alarm reaction, timing, code out
`timescale 1ns/1ps

module threshold_relay_output
  import relay_out_pkg::*;
#(
  parameter int CODE_W = 16
) (
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // source channel
  input wire logic src_valid_in,
  input wire logic signed [31:0] src_value_in,
  input wire logic src_error_in,
  input wire logic source_over_range_flag_in,
  input wire logic source_under_range_flag_in,
  // timing base, one pulse per time unit
  input wire logic tick_in,
  // link to the modbus master
  input wire logic out_active_in,
  output logic [CODE_W-1:0] out_code_out,
  output logic out_update_out,
  // interrupt
  output logic irq_out
);

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctrl;
  logic signed [31:0] level;
  logic signed [31:0] lower;
  logic signed [31:0] upper;
  logic [31:0] hyst;
  logic [31:0] on_delay;
  logic [31:0] off_delay;
  logic [31:0] min_on;
  logic [31:0] min_off;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;

  // ****************************************
  // apb decode
  // ****************************************
  wire setup = psel_in & ~penable_in;
  wire access = psel_in & penable_in & ce_in;
  wire wr = access & pwrite_in;
  wire hit_ctrl = paddr_in == ADDR_CTRL;
  wire hit_level = paddr_in == ADDR_LEVEL;
  wire hit_lower = paddr_in == ADDR_LOWER;
  wire hit_upper = paddr_in == ADDR_UPPER;
  wire hit_hyst = paddr_in == ADDR_HYST;
  wire hit_on = paddr_in == ADDR_ON_DELAY;
  wire hit_off = paddr_in == ADDR_OFF_DELAY;
  wire hit_min_on = paddr_in == ADDR_MIN_ON;
  wire hit_min_off = paddr_in == ADDR_MIN_OFF;
  wire hit_status = paddr_in == ADDR_STATUS;
  wire hit_irq_st = paddr_in == ADDR_IRQ_STATUS;
  wire hit_irq_en = paddr_in == ADDR_IRQ_ENABLE;
  wire hit_irq_clr = paddr_in == ADDR_IRQ_CLEAR;
  wire hit = hit_ctrl | hit_level | hit_lower | hit_upper | hit_hyst | hit_on | hit_off
             | hit_min_on | hit_min_off | hit_status | hit_irq_st | hit_irq_en | hit_irq_clr;

  assign pready_out = access;
  assign pslverr_out = access & ~hit;

  // ****************************************
  // source sampling and alarm
  // ****************************************
  logic signed [31:0] value;
  logic alarm;
  relay_state_e state;
  logic [31:0] pend_cnt;
  logic [31:0] age_cnt;
  logic [CODE_W-1:0] code;

  wire sample_alarm = src_error_in | source_over_range_flag_in | source_under_range_flag_in;
  wire next_alarm = src_valid_in ? sample_alarm : alarm;
  wire alarm_rise = next_alarm & ~alarm;

  wire mode_e mode = mode_e'(ctrl[CTRL_MODE_LSB +: CTRL_FIELD_W]);
  wire alarm_e reaction = alarm_e'(ctrl[CTRL_ALARM_LSB +: CTRL_FIELD_W]);

  // ****************************************
  // comparison with hysteresis, widened against overflow
  // ****************************************
  wire signed [33:0] v = {{2{value[31]}}, value};
  wire signed [33:0] h = {2'b00, hyst};
  wire signed [33:0] lvl_hi = {{2{level[31]}}, level} + h;
  wire signed [33:0] lvl_lo = {{2{level[31]}}, level} - h;
  wire signed [33:0] low_hi = {{2{lower[31]}}, lower} + h;
  wire signed [33:0] low_lo = {{2{lower[31]}}, lower} - h;
  wire signed [33:0] up_hi = {{2{upper[31]}}, upper} + h;
  wire signed [33:0] up_lo = {{2{upper[31]}}, upper} - h;
  wire above_on = v > lvl_hi;
  wire above_off = v < lvl_lo;
  wire below_on = v < lvl_lo;
  wire below_off = v > lvl_hi;
  wire band_in = (v > low_hi) && (v < up_lo);
  wire band_out = (v < low_lo) || (v > up_hi);
  wire is_high = state == ST_HIGH;

  logic cmp_req;
  always_comb begin
    case (mode)
      MODE_ABOVE: cmp_req = is_high ? ~above_off : above_on;
      MODE_BELOW: cmp_req = is_high ? ~below_off : below_on;
      MODE_INSIDE: cmp_req = is_high ? ~band_out : band_in;
      MODE_OUTSIDE: cmp_req = is_high ? ~band_in : band_out;
      default: cmp_req = 1'b0;
    endcase
  end

  // alarm reaction takes precedence over the comparison
  logic req;
  always_comb begin
    if (!alarm) begin
      req = cmp_req;
    end else begin
      case (reaction)
        ALARM_IMM_LOW: req = 1'b0;
        ALARM_IMM_HIGH: req = 1'b1;
        ALARM_TIMED_LOW: req = 1'b0;
        ALARM_TIMED_HIGH: req = 1'b1;
        default: req = is_high;
      endcase
    end
  end

  // ****************************************
  // timing: switch delay and minimum hold
  // ****************************************
  wire disabled = mode == MODE_DISABLED;
  wire forced = alarm & ((reaction == ALARM_IMM_LOW) | (reaction == ALARM_IMM_HIGH));
  wire pending = (req != is_high) & ~disabled;
  wire [31:0] need_delay = is_high ? off_delay : on_delay;
  wire [31:0] need_hold = is_high ? min_on : min_off;
  wire timed_ok = (pend_cnt >= need_delay) && (age_cnt >= need_hold);

  relay_state_e next_state;
  always_comb begin
    if (disabled) begin
      next_state = ST_LOW;
    end else if (forced) begin
      next_state = relay_state_e'(req);
    end else if (pending && timed_ok) begin
      next_state = relay_state_e'(req);
    end else begin
      next_state = state;
    end
  end

  wire changed = next_state != state;
  wire rise = changed & (next_state == ST_HIGH);
  wire fall = changed & (next_state == ST_LOW);
  wire [CODE_W-1:0] full_code = {CODE_W{1'b1}};
  wire [CODE_W-1:0] next_code = (out_active_in && !disabled && next_state == ST_HIGH)
                                ? full_code : {CODE_W{1'b0}};

  // ****************************************
  // interrupt events, set wins over clear
  // ****************************************
  wire [IRQ_W-1:0] events = {alarm_rise, fall, rise};
  wire [IRQ_W-1:0] clr_mask = (wr & hit_irq_clr) ? pwdata_in[IRQ_W-1:0] : {IRQ_W{1'b0}};
  wire [IRQ_W-1:0] next_irq = (irq_status & ~clr_mask) | events;
  assign irq_out = |(irq_status & irq_enable);

  // ****************************************
  // read mux
  // ****************************************
  wire [31:0] status_word = {code, 13'h0000, pending, alarm, is_high};
  wire [31:0] rdata = hit_ctrl ? ctrl
                    : hit_level ? level
                    : hit_lower ? lower
                    : hit_upper ? upper
                    : hit_hyst ? hyst
                    : hit_on ? on_delay
                    : hit_off ? off_delay
                    : hit_min_on ? min_on
                    : hit_min_off ? min_off
                    : hit_status ? status_word
                    : hit_irq_st ? {29'h0000_0000, irq_status}
                    : hit_irq_en ? {29'h0000_0000, irq_enable}
                    : REG_RESET;

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctrl <= REG_RESET;
      level <= REG_RESET;
      lower <= REG_RESET;
      upper <= REG_RESET;
      hyst <= REG_RESET;
      on_delay <= REG_RESET;
      off_delay <= REG_RESET;
      min_on <= REG_RESET;
      min_off <= REG_RESET;
      irq_enable <= {IRQ_W{1'b0}};
      prdata_out <= REG_RESET;
    end else if (ce_in) begin
      if (wr && hit_ctrl) ctrl <= pwdata_in;
      if (wr && hit_level) level <= pwdata_in;
      if (wr && hit_lower) lower <= pwdata_in;
      if (wr && hit_upper) upper <= pwdata_in;
      if (wr && hit_hyst) hyst <= pwdata_in;
      if (wr && hit_on) on_delay <= pwdata_in;
      if (wr && hit_off) off_delay <= pwdata_in;
      if (wr && hit_min_on) min_on <= pwdata_in;
      if (wr && hit_min_off) min_off <= pwdata_in;
      if (wr && hit_irq_en) irq_enable <= pwdata_in[IRQ_W-1:0];
      if (setup) prdata_out <= rdata;
    end
  end

  // ****************************************
  // relay state, counters and output code
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      value <= REG_RESET;
      alarm <= 1'b0;
      state <= ST_LOW;
      pend_cnt <= REG_RESET;
      age_cnt <= REG_RESET;
      code <= {CODE_W{1'b0}};
      out_code_out <= {CODE_W{1'b0}};
      out_update_out <= 1'b0;
      irq_status <= {IRQ_W{1'b0}};
    end else if (ce_in) begin
      if (src_valid_in && !sample_alarm) value <= src_value_in;
      alarm <= next_alarm;
      state <= next_state;
      if (!pending || changed) begin
        pend_cnt <= REG_RESET;
      end else if (tick_in && pend_cnt != 32'hFFFF_FFFF) begin
        pend_cnt <= pend_cnt + 32'h0000_0001;
      end
      if (changed) begin
        age_cnt <= REG_RESET;
      end else if (tick_in && age_cnt != 32'hFFFF_FFFF) begin
        age_cnt <= age_cnt + 32'h0000_0001;
      end
      code <= next_code;
      out_code_out <= next_code;
      out_update_out <= next_code != code;
      irq_status <= next_irq;
    end
  end

endmodule

// ---- relay_out_pkg.sv ----
// constants, register map and enumerations of the threshold relay output
package relay_out_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_LOWER = 8'h08;
  localparam logic [7:0] ADDR_UPPER = 8'h0C;
  localparam logic [7:0] ADDR_HYST = 8'h10;
  localparam logic [7:0] ADDR_ON_DELAY = 8'h14;
  localparam logic [7:0] ADDR_OFF_DELAY = 8'h18;
  localparam logic [7:0] ADDR_MIN_ON = 8'h1C;
  localparam logic [7:0] ADDR_MIN_OFF = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h28;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h30;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ALARM_LSB = 4;
  localparam int CTRL_FIELD_W = 3;
  localparam int STAT_STATE_BIT = 0;
  localparam int STAT_ALARM_BIT = 1;
  localparam int STAT_PEND_BIT = 2;
  localparam int STAT_CODE_LSB = 16;
  localparam int IRQ_RISE_BIT = 0;
  localparam int IRQ_FALL_BIT = 1;
  localparam int IRQ_ALARM_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [2:0] {
    MODE_DISABLED = 3'b000,
    MODE_ABOVE = 3'b001,
    MODE_BELOW = 3'b010,
    MODE_INSIDE = 3'b011,
    MODE_OUTSIDE = 3'b100
  } mode_e;

  typedef enum logic [2:0] {
    ALARM_HOLD = 3'b000,
    ALARM_IMM_LOW = 3'b001,
    ALARM_IMM_HIGH = 3'b010,
    ALARM_TIMED_LOW = 3'b011,
    ALARM_TIMED_HIGH = 3'b100
  } alarm_e;

  typedef enum logic {
    ST_LOW = 1'b0,
    ST_HIGH = 1'b1
  } relay_state_e;

endpackage

// ---- relay_out_sva.sv ----
// port-level checks of the threshold relay output
`timescale 1ns/1ps
module relay_out_sva #(
  parameter int CODE_W = 16
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic out_active_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [CODE_W-1:0] out_code_out,
  input wire logic out_update_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire acc = psel_in && penable_in && ce_in;
  a_code_legal: assert property (out_code_out == '0 || out_code_out == '1)
    else $error("code neither zero nor full");
  a_update_mark: assert property (out_update_out && $past(ce_in)
    |-> out_code_out != $past(out_code_out))
    else $error("update pulse without change");
  a_quiet_hold: assert property (!out_update_out |-> $stable(out_code_out))
    else $error("code changed without update");
  a_active_gate: assert property ($rose(out_code_out[0]) |-> $past(out_active_in))
    else $error("code rose while inactive");
  a_inactive_zero: assert property ((!out_active_in && ce_in) [*2] |-> out_code_out == '0)
    else $error("inactive output not zero");
  a_ready_access: assert property (psel_in && !penable_in ##1 psel_in && penable_in
    |-> pready_out == ce_in)
    else $error("no ready in access phase");
  a_idle_quiet: assert property (!psel_in |-> !pready_out && !pslverr_out)
    else $error("bus answer while idle");
  a_err_unmapped: assert property (acc && paddr_in > 8'h30 |-> pslverr_out)
    else $error("no error on unmapped address");
  a_ok_mapped: assert property (acc && paddr_in[1:0] == 2'h0 && paddr_in <= 8'h30
    |-> !pslverr_out)
    else $error("error on mapped address");
  c_rise: cover property ($rose(out_code_out[0]));
  c_fall: cover property ($fell(out_code_out[0]));
  c_err: cover property (pslverr_out);
endmodule

// ---- modbus_slave_model.sv ----
// remote slave that keeps the last output register value written to it
`timescale 1ns/1ps
module modbus_slave_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [15:0] code_in,
  input wire logic update_in,
  output logic [15:0] holding_out
);
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      holding_out <= 16'h0000;
    end else if (update_in) begin
      holding_out <= code_in;
    end
  end
endmodule

// ---- testbench.sv ----
// self-checking bench for the threshold relay output
`timescale 1ns/1ps
module testbench;
  import relay_out_pkg::*;
  logic clock_in = 1'h0, rst_in = 1'h1, ce_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0;
  logic pwrite_in = 1'h0, src_valid_in = 1'h0, src_error_in = 1'h0, tick_in = 1'h0;
  logic source_over_range_flag_in = 1'h0, source_under_range_flag_in = 1'h0;
  logic out_active_in = 1'h1, pready_out, pslverr_out, e, out_update_out, irq_out;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, r;
  logic signed [31:0] src_value_in = 32'h0;
  logic [15:0] out_code_out, held;
  int errors = 0, compares = 0;
  always #5 clock_in = ~clock_in;
  threshold_relay_output u_threshold_relay_output (.clock_in, .rst_in, .ce_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .src_valid_in, .src_value_in, .src_error_in, .source_over_range_flag_in,
    .source_under_range_flag_in, .tick_in, .out_active_in, .out_code_out, .out_update_out,
    .irq_out);
  modbus_slave_model u_modbus_slave_model (.clock_in, .rst_in, .code_in(out_code_out),
    .update_in(out_update_out), .holding_out(held));
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'h1;
    do @(posedge clock_in); while (pready_out !== 1'h1);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
    @(posedge clock_in);
  endtask
  // one source sample; flags are error, over, under
  task automatic samp(input logic [31:0] v, input logic [2:0] f);
    src_valid_in <= 1'h1;
    src_value_in <= v;
    {src_error_in, source_over_range_flag_in, source_under_range_flag_in} <= f;
    @(posedge clock_in);
    src_valid_in <= 1'h0;
    {src_error_in, source_over_range_flag_in, source_under_range_flag_in} <= 3'h0;
    repeat (3) @(posedge clock_in);
  endtask
  task automatic tk;
    tick_in <= 1'h1;
    @(posedge clock_in);
    tick_in <= 1'h0;
    repeat (3) @(posedge clock_in);
  endtask
  task automatic chk(input logic [15:0] x);
    cmp(32'(out_code_out), 32'(x));
    cmp(32'(held), 32'(x));
  endtask
  task automatic cfg(input logic [31:0] c, input logic [31:0] l, input logic [31:0] h);
    xfer(1'h1, ADDR_CTRL, c);
    xfer(1'h1, ADDR_LEVEL, l);
    xfer(1'h1, ADDR_HYST, h);
  endtask
  task automatic t_regs;
    xfer(1'h0, ADDR_CTRL, 32'h0);
    cmp(r, REG_RESET);
    xfer(1'h1, ADDR_STATUS, 32'hFFFF_FFFF);
    xfer(1'h0, ADDR_STATUS, 32'h0);
    cmp(r, REG_RESET);
    xfer(1'h1, ADDR_IRQ_CLEAR, 32'h7);
    xfer(1'h0, ADDR_IRQ_CLEAR, 32'h0);
    cmp(r, 32'h0);
    xfer(1'h1, 8'h34, 32'h5);
    cmp(32'(e), 32'h1);
    xfer(1'h0, 8'h34, 32'h0);
    cmp({r[31:1], e}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_levels;
    cfg(32'(MODE_ABOVE), 32'h64, 32'h5);
    samp(32'h69, 3'h0); chk(16'h0);
    samp(32'h6A, 3'h0); chk(16'hFFFF);
    samp(32'h5F, 3'h0); chk(16'hFFFF);
    samp(32'h5E, 3'h0); chk(16'h0);
    cfg(32'(MODE_BELOW), 32'h1E, 32'h5);
    samp(32'h19, 3'h0); chk(16'h0);
    samp(32'h18, 3'h0); chk(16'hFFFF);
    samp(32'h23, 3'h0); chk(16'hFFFF);
    samp(32'h24, 3'h0); chk(16'h0);
    xfer(1'h1, ADDR_LOWER, 32'h0A);
    xfer(1'h1, ADDR_UPPER, 32'h14);
    cfg(32'(MODE_INSIDE), 32'h0, 32'h0);
    samp(32'h0F, 3'h0); chk(16'hFFFF);
    samp(32'h15, 3'h0); chk(16'h0);
    xfer(1'h1, ADDR_CTRL, 32'(MODE_OUTSIDE));
    samp(32'h15, 3'h0); chk(16'hFFFF);
    samp(32'h0F, 3'h0); chk(16'h0);
    $display("test levels done");
  endtask
  task automatic t_alarm;
    alarm_e a[3] = '{ALARM_IMM_LOW, ALARM_IMM_HIGH, ALARM_HOLD};
    logic [31:0] v[3] = '{32'hC8, 32'h0, 32'hC8};
    logic [15:0] x[3] = '{16'h0, 16'hFFFF, 16'hFFFF};
    logic [31:0] w[3] = '{32'hC8, 32'h0, 32'h0};
    for (int i = 0; i < 3; i++) begin
      cfg({25'h0, a[i], 1'h0, MODE_ABOVE}, 32'h64, 32'h0);
      samp(v[i], 3'h0);
      samp(32'h0, 3'h4 >> i); chk(x[i]);
      samp(w[i], 3'h0); chk(w[i] == 32'hC8 ? 16'hFFFF : 16'h0);
    end
    $display("test alarm done");
  endtask
  task automatic t_irq;
    cfg(32'(MODE_ABOVE), 32'h64, 32'h0);
    xfer(1'h1, ADDR_IRQ_CLEAR, 32'h7);
    xfer(1'h1, ADDR_IRQ_ENABLE, 32'h1);
    cmp(32'(irq_out), 32'h0);
    samp(32'hC8, 3'h0);
    cmp(32'(irq_out), 32'h1);
    xfer(1'h0, ADDR_IRQ_STATUS, 32'h0);
    cmp(r & 32'h1, 32'h1);
    xfer(1'h1, ADDR_IRQ_ENABLE, 32'h0);
    cmp(32'(irq_out), 32'h0);
    xfer(1'h1, ADDR_IRQ_ENABLE, 32'h1);
    cmp(32'(irq_out), 32'h1);
    xfer(1'h1, ADDR_IRQ_CLEAR, 32'h1);
    cmp(32'(irq_out), 32'h0);
    $display("test irq done");
  endtask
  task automatic t_disabled;
    cfg(32'(MODE_DISABLED), 32'h64, 32'h0);
    samp(32'hC8, 3'h0); chk(16'h0);
    xfer(1'h1, ADDR_CTRL, 32'(MODE_ABOVE));
    samp(32'hC8, 3'h0); chk(16'hFFFF);
    out_active_in <= 1'h0;
    repeat (3) @(posedge clock_in);
    chk(16'h0);
    out_active_in <= 1'h1;
    repeat (3) @(posedge clock_in);
    chk(16'hFFFF);
    // clock enable low freezes the code even though the output is switched off
    ce_in <= 1'h0;
    out_active_in <= 1'h0;
    repeat (3) @(posedge clock_in);
    chk(16'hFFFF);
    ce_in <= 1'h1;
    out_active_in <= 1'h1;
    repeat (3) @(posedge clock_in);
    chk(16'hFFFF);
    $display("test disabled done");
  endtask
  task automatic t_timed;
    cfg({25'h0, ALARM_TIMED_LOW, 1'h0, MODE_ABOVE}, 32'h64, 32'h0);
    samp(32'h0, 3'h0); chk(16'h0);
    xfer(1'h1, ADDR_ON_DELAY, 32'h2);
    xfer(1'h1, ADDR_MIN_ON, 32'h2);
    samp(32'hC8, 3'h0); chk(16'h0);
    tk; chk(16'h0);
    tk; chk(16'hFFFF);
    samp(32'h0, 3'h2); chk(16'hFFFF);
    xfer(1'h0, ADDR_STATUS, 32'h0);
    cmp(r, 32'hFFFF_0007);
    tk; chk(16'hFFFF);
    tk; chk(16'h0);
    xfer(1'h1, ADDR_CTRL, {25'h0, ALARM_TIMED_HIGH, 1'h0, MODE_ABOVE});
    chk(16'h0);
    tk; tk; chk(16'hFFFF);
    xfer(1'h1, ADDR_OFF_DELAY, 32'h3);
    samp(32'h0, 3'h0); chk(16'hFFFF);
    tk; tk; chk(16'hFFFF);
    tk; chk(16'h0);
    $display("test timed done");
  endtask
  task automatic print_verdict;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock_in);
    rst_in <= 1'h0;
    @(posedge clock_in);
    t_regs;
    t_levels;
    t_alarm;
    t_irq;
    t_disabled;
    t_timed;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    errors++;
    print_verdict;
  end
endmodule
bind threshold_relay_output relay_out_sva #(.CODE_W(CODE_W)) u_relay_out_sva (.clock_in,
  .rst_in, .ce_in, .psel_in, .penable_in, .paddr_in, .out_active_in, .pready_out,
  .pslverr_out, .out_code_out, .out_update_out);
